// ---- rtl/bfc_defs.svh ----
// Offsets, field positions, reset values and decode constants of the forwarding control
`ifndef BFC_DEFS_SVH
`define BFC_DEFS_SVH

// ----------------------------------------------------------------------------
// Configuration offsets
// ----------------------------------------------------------------------------
`define BFC_OFF_CAP_ID 8'h40
`define BFC_OFF_BRCTL 8'h3E
`define BFC_CAP_ID_VAL 16'h000D
`define BFC_BRCTL_RST 6'h00
`define BFC_BRCTL_W 6

// ----------------------------------------------------------------------------
// Bridge control fields
// ----------------------------------------------------------------------------
`define BFC_BIT_PARITY 0
`define BFC_BIT_SYSERR 1
`define BFC_BIT_ALIAS 2
`define BFC_BIT_DISP 3
`define BFC_BIT_DISP16 4
`define BFC_BIT_MAM 5

// ----------------------------------------------------------------------------
// Legacy display decode
// ----------------------------------------------------------------------------
`define BFC_DISP_MEM_LO 32'h000A_0000
`define BFC_DISP_MEM_HI 32'h000B_FFFF
`define BFC_DISP_IO_A_LO 10'h3B0
`define BFC_DISP_IO_A_HI 10'h3BB
`define BFC_DISP_IO_B_LO 10'h3C0
`define BFC_DISP_IO_B_HI 10'h3DF
`define BFC_IO_LOW64K_HI 32'h0000_FFFF

`endif

// ---- rtl/bfc_pkg.sv ----
// Types shared by the forwarding control
`default_nettype none

package bfc_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } bfc_cfg_req_t;

  typedef struct packed {
    logic valid;
    logic upstream;
    logic is_io;
    logic [31:0] addr;
    logic mem_window_hit;
  } bfc_dec_req_t;

  typedef struct packed {
    logic io_space_en;
    logic mem_space_en;
    logic primary_syserr_report_en;
  } bfc_cmd_t;

  typedef struct packed {
    logic [5:0] brctl;
    logic [15:0] rdata;
    logic ack;
    logic dec_done;
    logic fwd_dn;
    logic fwd_up;
    logic serr_prev;
    logic serr_fwd;
    logic err_report;
    logic poison;
  } bfc_state_t;

endpackage

`default_nettype wire

// ---- rtl/bfc_top.sv ----
// Legacy display forwarding, alias blocking and secondary error forwarding
// Notes on behaviour
// - Display forwarding ignores windows and alias blocking
// - Display memory window A0000h through BFFFFh
// - Display I/O: upper zero, 3B0-3BB, 3C0-3DF
// - Alias blocking only inside I/O window, 64K
// - Alias blocking refuses upper 768 bytes downstream
// - Alias blocking forwards upper 768 bytes upstream
// - Alias blocking clear forwards whole I/O window
// - System error forwarded needs assert, both enables
// - Error forwarding enable resets zero, blocks events
// - Parity response clear ignores secondary errors
// - Parity response set reports secondary errors
// - Data error always poisons upstream data
// - Capability identifier at 40h reads 0Dh
// - Display forwarding gated by space enables
`include "bfc_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module bfc_top (
  input wire logic clk,
  input wire logic srst,
  input wire bfc_pkg::bfc_cfg_req_t cfg_req,
  output logic [15:0] cfg_rdata,
  output logic cfg_ack,
  input wire bfc_pkg::bfc_cmd_t cmd,
  input wire logic [31:0] io_base,
  input wire logic [31:0] io_limit,
  input wire bfc_pkg::bfc_dec_req_t dec_req,
  output logic dec_done,
  output logic fwd_dn,
  output logic fwd_up,
  input wire logic sec_serr,
  input wire logic sec_addr_err,
  input wire logic sec_attr_err,
  input wire logic sec_data_err,
  output logic pri_serr_fwd,
  output logic sec_err_report,
  output logic data_poison,
  output logic master_abort_mode
);

  bfc_pkg::bfc_state_t s_q;
  bfc_pkg::bfc_state_t s_d;

  logic legacy_io_alias_block_en;
  logic secondary_syserr_fwd_en;
  logic secondary_parity_response_en;
  logic disp_en;
  logic disp16;
  logic in_io_window;
  logic in_low64k;
  logic alias_hit;
  logic disp_mem_hit;
  logic disp_io_hit;
  logic disp_hit;
  logic dn_decision;
  logic up_decision;
  logic [9:0] low10;

  assign legacy_io_alias_block_en = s_q.brctl[`BFC_BIT_ALIAS];
  assign secondary_syserr_fwd_en = s_q.brctl[`BFC_BIT_SYSERR];
  assign secondary_parity_response_en = s_q.brctl[`BFC_BIT_PARITY];
  assign disp_en = s_q.brctl[`BFC_BIT_DISP];
  assign disp16 = s_q.brctl[`BFC_BIT_DISP16];
  assign low10 = dec_req.addr[9:0];

  // ----------------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------------
  assign in_io_window = (dec_req.addr >= io_base) && (dec_req.addr <= io_limit);
  assign in_low64k = dec_req.addr <= `BFC_IO_LOW64K_HI;
  // Top 768 bytes of each 1 KB block: offset within block at or above 100h
  assign alias_hit = dec_req.addr[9:8] != 2'b00;
  assign disp_mem_hit = (dec_req.addr >= `BFC_DISP_MEM_LO) && (dec_req.addr <= `BFC_DISP_MEM_HI);
  assign disp_io_hit = (dec_req.addr[31:16] == 16'h0000)
    && (!disp16 || dec_req.addr[15:10] == 6'h00)
    && (((low10 >= `BFC_DISP_IO_A_LO) && (low10 <= `BFC_DISP_IO_A_HI))
      || ((low10 >= `BFC_DISP_IO_B_LO) && (low10 <= `BFC_DISP_IO_B_HI)));
  // Display hit still needs the matching space enable
  assign disp_hit = disp_en && (dec_req.is_io ? (disp_io_hit && cmd.io_space_en)
                                              : (disp_mem_hit && cmd.mem_space_en));

  always_comb
  begin
    dn_decision = 1'b0;
    up_decision = 1'b0;
    if (!dec_req.upstream)
    begin
      if (disp_hit)
        dn_decision = 1'b1;
      else if (dec_req.is_io)
        // Blocking applies only inside the window and the low 64 KB
        dn_decision = cmd.io_space_en && in_io_window
          && !(legacy_io_alias_block_en && in_low64k && alias_hit);
      else
        dn_decision = cmd.mem_space_en && dec_req.mem_window_hit;
    end
    else
    begin
      // Display addresses owned downstream never travel upstream
      if (disp_en && (dec_req.is_io ? disp_io_hit : disp_mem_hit))
        up_decision = 1'b0;
      else if (dec_req.is_io)
        up_decision = !in_io_window
          || (legacy_io_alias_block_en && in_low64k && alias_hit);
      else
        up_decision = !dec_req.mem_window_hit;
    end
  end

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.ack = cfg_req.wr || cfg_req.rd;
    s_d.rdata = 16'h0000;
    if (cfg_req.wr && cfg_req.addr == `BFC_OFF_BRCTL)
      s_d.brctl = cfg_req.wdata[`BFC_BRCTL_W-1:0];
    // Capability identifier has no storage, so writes fall away
    if (cfg_req.rd)
    begin
      if (cfg_req.addr == `BFC_OFF_CAP_ID)
        s_d.rdata = `BFC_CAP_ID_VAL;
      else if (cfg_req.addr == `BFC_OFF_BRCTL)
        s_d.rdata = {10'h000, s_q.brctl};
    end
    s_d.dec_done = dec_req.valid;
    s_d.fwd_dn = dec_req.valid && dn_decision;
    s_d.fwd_up = dec_req.valid && up_decision;
    s_d.serr_prev = sec_serr;
    // One event per assertion edge of the secondary error line
    s_d.serr_fwd = sec_serr && !s_q.serr_prev
      && secondary_syserr_fwd_en && cmd.primary_syserr_report_en;
    s_d.err_report = secondary_parity_response_en
      && (sec_addr_err || sec_attr_err || sec_data_err);
    s_d.poison = sec_data_err;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_q <= '0;
      s_q.brctl <= `BFC_BRCTL_RST;
    end
    else
      s_q <= s_d;
  end

  assign cfg_rdata = s_q.rdata;
  assign cfg_ack = s_q.ack;
  assign dec_done = s_q.dec_done;
  assign fwd_dn = s_q.fwd_dn;
  assign fwd_up = s_q.fwd_up;
  assign pri_serr_fwd = s_q.serr_fwd;
  assign sec_err_report = s_q.err_report;
  assign data_poison = s_q.poison;
  assign master_abort_mode = s_q.brctl[`BFC_BIT_MAM];

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_disp_forward: assert property (
    dec_req.valid && !dec_req.upstream && disp_hit |=> fwd_dn)
    else $error("display access not forwarded");

  a_disp_mem_range: assert property (
    dec_req.valid && !dec_req.upstream && !dec_req.is_io && disp_en && cmd.mem_space_en
    && dec_req.addr == 32'h000C_0000 && !dec_req.mem_window_hit |=> !fwd_dn)
    else $error("display memory window too wide");

  a_alias_block_dn: assert property (
    dec_req.valid && !dec_req.upstream && dec_req.is_io && !disp_hit && legacy_io_alias_block_en
    && in_low64k && alias_hit |=> !fwd_dn)
    else $error("alias address forwarded downstream");

  a_alias_fwd_up: assert property (
    dec_req.valid && dec_req.upstream && dec_req.is_io && !disp_en && legacy_io_alias_block_en
    && in_io_window && in_low64k && alias_hit |=> fwd_up)
    else $error("alias address not forwarded upstream");

  a_window_all_dn: assert property (
    dec_req.valid && !dec_req.upstream && dec_req.is_io && cmd.io_space_en && in_io_window
    && !legacy_io_alias_block_en |=> fwd_dn)
    else $error("io window address dropped");

  a_serr_gate: assert property (
    pri_serr_fwd |-> $past(secondary_syserr_fwd_en) && $past(cmd.primary_syserr_report_en)
    && $past(sec_serr) && !$past(sec_serr, 2))
    else $error("system error forwarded without cause");

  a_serr_reset: assert property (
    $fell(srst) |-> !secondary_syserr_fwd_en && !pri_serr_fwd)
    else $error("error forwarding enable not cleared");

  a_parity_ignore: assert property (
    !secondary_parity_response_en && !cfg_req.wr |=> !sec_err_report)
    else $error("error reported while response disabled");

  a_parity_report: assert property (
    secondary_parity_response_en && (sec_addr_err || sec_attr_err || sec_data_err) |=> sec_err_report)
    else $error("secondary error not reported");

  a_io_space_gate: assert property (
    dec_req.valid && !dec_req.upstream && dec_req.is_io && !cmd.io_space_en |=> !fwd_dn)
    else $error("io access forwarded with io space off");

  a_poison_always: assert property (
    sec_data_err |=> data_poison)
    else $error("data error not poisoned");

  a_cap_id_read: assert property (
    cfg_req.rd && cfg_req.addr == `BFC_OFF_CAP_ID |=> cfg_ack && cfg_rdata == 16'h000D)
    else $error("capability identifier misread");

endmodule // bfc_top

`default_nettype wire

// ---- verification/bfc_sec_model.sv ----
// Secondary bus agent model that raises error lines on request
`timescale 1ns/100ps
`default_nettype none

module bfc_sec_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] ev,
  output logic sec_serr,
  output logic sec_addr_err,
  output logic sec_attr_err,
  output logic sec_data_err
);
  // One-cycle events, so each request is a fresh rise of the error line
  always_ff @(posedge clk)
  begin
    if (srst)
      {sec_serr, sec_addr_err, sec_attr_err, sec_data_err} <= 4'h0;
    else
      {sec_serr, sec_addr_err, sec_attr_err, sec_data_err} <= ev;
  end
endmodule // bfc_sec_model
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the forwarding control
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  bfc_pkg::bfc_cfg_req_t cfg_req = '0;
  bfc_pkg::bfc_cmd_t cmd = '0;
  bfc_pkg::bfc_dec_req_t dec_req = '0;
  logic [31:0] io_base = 32'h0000_0400;
  logic [31:0] io_limit = 32'h0001_03FF;
  logic [3:0] ev = 4'h0;
  logic [15:0] cfg_rdata;
  logic cfg_ack, dec_done, fwd_dn, fwd_up, pri_serr_fwd, sec_err_report, data_poison, master_abort_mode;
  logic sec_serr, sec_addr_err, sec_attr_err, sec_data_err;
  int errors = 0;
  int samples_checked = 0;
  int seed = 10401;
  logic [5:0] br = 6'h00;
  logic [31:0] r, x;
  logic [31:0] corner [12] = '{32'h3B0, 32'h3BB, 32'h3BC, 32'h3C0, 32'h3DF, 32'h3E0, 32'h7C5, 32'hFFFF,
    32'hA_0000, 32'hB_FFFF, 32'h9_FFFF, 32'hC_0000};

  bfc_top dut (.clk, .srst, .cfg_req, .cfg_rdata, .cfg_ack, .cmd, .io_base, .io_limit, .dec_req, .dec_done,
    .fwd_dn, .fwd_up, .sec_serr, .sec_addr_err, .sec_attr_err, .sec_data_err, .pri_serr_fwd, .sec_err_report,
    .data_poison, .master_abort_mode);
  bfc_sec_model model (.clk, .srst, .ev, .sec_serr, .sec_addr_err, .sec_attr_err, .sec_data_err);

  always #50 clk = ~clk;

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task cfg(input logic w, input logic [7:0] ad, input logic [15:0] wd, input logic [15:0] exp);
    @(posedge clk);
    cfg_req <= '{wr: w, rd: !w, addr: ad, wdata: wd};
    @(posedge clk);
    cfg_req <= '0;
    #1;
    chk({15'h0, cfg_ack}, 16'h1);
    chk(cfg_rdata, exp);
    if (w && ad == 8'h3E)
      br = wd[5:0];
  endtask

  function logic disp(logic io, logic [31:0] a);
    if (!br[3])
      return 1'b0;
    if (!io)
      return a >= 32'h000A_0000 && a <= 32'h000B_FFFF;
    return a[31:16] == 16'h0 && (!br[4] || a[15:10] == 6'h0)
      && (a[9:0] inside {[10'h3B0:10'h3BB], [10'h3C0:10'h3DF]});
  endfunction

  function logic exp_fwd(logic up, logic io, logic hit, logic [31:0] a);
    logic win;
    logic al;
    win = a >= io_base && a <= io_limit;
    al = br[2] && a <= 32'h0000_FFFF && a[9:8] != 2'h0;
    if (up)
      return !disp(io, a) && (io ? (!win || al) : !hit);
    return (io ? cmd.io_space_en : cmd.mem_space_en) && (disp(io, a) || (io ? win && !al : hit));
  endfunction

  task dec(input logic up, input logic io, input logic hit, input logic [31:0] a);
    logic e;
    logic m;
    @(posedge clk);
    // Worked out after the edge, so a command change made just before is seen
    e = exp_fwd(up, io, hit, a);
    // Upstream gating by space enables is left open, so only judged with both on
    m = !up || (cmd.io_space_en && cmd.mem_space_en);
    dec_req <= '{valid: 1'b1, upstream: up, is_io: io, addr: a, mem_window_hit: hit};
    @(posedge clk);
    dec_req <= '0;
    #1;
    chk({13'h0, dec_done, fwd_dn, fwd_up & m}, {13'h0, 1'b1, !up & e, up & e & m});
  endtask

  task err(input logic [3:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 4'h0;
    @(posedge clk);
    #1;
    chk({13'h0, pri_serr_fwd, sec_err_report, data_poison},
      {13'h0, e[3] & br[1] & cmd.primary_syserr_report_en, br[0] & |e[2:0], e[0]});
  endtask

  initial
  begin
    #2_000_000;
    errors++;
    print_verdict();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    cfg(1'b0, 8'h3E, 16'h0, 16'h0);
    cfg(1'b0, 8'h40, 16'h0, 16'h000D);
    cfg(1'b1, 8'h40, 16'h00FF, 16'h0);
    cfg(1'b0, 8'h40, 16'h0, 16'h000D);
    cfg(1'b0, 8'h10, 16'h0, 16'h0);
    cmd <= 3'h7;
    err(4'hF);
    $display("test registers done");
    for (int i = 0; i < 32; i++)
    begin
      cfg(1'b1, 8'h3E, {10'h000, 6'($random(seed))}, 16'h0);
      cfg(1'b0, 8'h3E, 16'h0, {10'h000, br});
      chk({15'h0, master_abort_mode}, {15'h0, br[5]});
      cmd <= 3'($random(seed));
      for (int j = 0; j < 24; j++)
      begin
        r = $random(seed);
        x = $random(seed);
        x = r[3] ? corner[r[7:4] % 12] : (r[0] ? x & 32'h0001_FFFF : 32'h0009_0000 + (x & 32'h0003_FFFF));
        dec(r[1], r[0], r[2], x);
        err(r[11:8]);
      end
    end
    $display("test random done");
    // Reset in mid-run must clear every bridge control enable left by the random test; cmd keeps its random value
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    br = 6'h00;
    @(posedge clk);
    cfg(1'b0, 8'h3E, 16'h0, 16'h0);
    chk({15'h0, master_abort_mode}, 16'h0);
    err(4'hF);
    $display("test reset done");
    print_verdict();
  end
endmodule // tb
`default_nettype wire
